// *** hw/adc_serial_ctrl.sv ***
// Serial control and conversion sequencing of a four-channel SAR converter.
// Assumes asynchronous link pins and comparator, sampled by the 40 MHz clock.
//
// How it works
// - With chip select low, serial input is sampled on each serial-clock rise.
// - Leading zeros are ignored; the first one starts the control byte.
// - Single-ended codes 001,101,010,110 pick channels 0..3 against the common input.
// - Differential codes pick pairs 0/1 and 2/3; 101 and 110 swap polarity.
// - Reply holds a zero, twelve result bits, three zeros.
// - Results leave MSB first on falling edges; bipolar is two's complement.
// - Track/hold acquires during the last three control bits; mode bits pick clock.
// - External mode: strobe high one period, then twelve falling edges give decisions.
// - External mode: chip select high floats strobe and output; strobe low after fall.
// - Internal mode: strobe low during conversion, at most 7.5 us; stays low longer while the result FIFO is full.
// - Internal mode: held result; next falling edge after strobe rise gives MSB.
// - Internal mode: chip select high blocks input, floats output, keeps strobe driven.
// - Conversion starts on the falling edge after the eighth control bit.
// - Start bit accepted when idle, or after result bit 5 went out.
// - Chip select toggling aborts an external-clock conversion; next one starts afresh.
// - Overlapped conversions every 15 or 16 clocks with chip select low.
// - Mode bits: 00 full power-down, 01 fast, 10 internal, 11 external clock.
// - Control byte: start, three selects, polarity, input config, two mode bits.
// - Out of reset: internal-clock mode, strobe high, output shifts zeros.
`timescale 1ns/1ps
module adc_serial_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // Serial link.
  input  wire logic        CS_N_I,
  input  wire logic        SCLK_I,
  input  wire logic        DIN_I,
  output logic             DOUT_O,
  output logic             DOUT_OE_O,
  output logic             CONV_STROBE_O,
  output logic             CONV_STROBE_OE_O,
  // Analog front end.
  input  wire logic        COMP_I,
  input  wire logic        HW_SHUTDOWN_N_I,
  output logic [11:0]      SAR_DAC_O,
  output logic             TRACK_O,
  output mux_sel_s         MUX_SEL_O,
  output logic             POWER_DOWN_O,
  // Result stream.
  output result_s          RESULT_O,
  output logic             RESULT_VALID_O,
  input  wire logic        RESULT_READY_I,
  output logic             OVERRUN_O
);

  typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_CTRL = 2'b10} rx_e;
  typedef enum logic [2:0] {CV_IDLE = 3'b001, CV_EXT = 3'b010, CV_INT = 3'b100} cv_e;

  logic [4:0]  pin_meta_reg;
  logic [4:0]  pin_sync_reg;
  logic        sclk_d_reg;
  logic        cs_n_d_reg;
  rx_e         rx_state_reg;
  logic [3:0]  rx_cnt_reg;
  logic [7:0]  rx_shift_reg;
  logic        ctrl_ready_reg;
  logic [7:0]  ctrl_reg;
  logic        clk_ext_reg;
  logic        pd_req_reg;
  logic        cs_toggled_reg;
  cv_e         cv_state_reg;
  logic [3:0]  step_reg;
  logic [11:0] sar_bits_reg;
  logic [OUT_SR_W-1:0] out_sr_reg;
  logic [8:0]  int_low_cnt_reg;

  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        comp;
  logic        hw_shutdown_n_n;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        hunt_ok;
  logic        conv_start;
  logic        new_ext;
  logic        bip;
  logic        tick;
  logic        fifo_in_ready;
  logic        conv_step;
  logic        conv_last;
  logic [3:0]  idx;
  logic [11:0] dec_bits;
  logic [11:0] code_out;
  result_s     push_word;

  function automatic mux_sel_s decode_mux(input logic [2:0] sel, input logic sgl);
    mux_sel_s m;
    m.neg_common = sgl;
    unique case (sel)
      SEL_CH1: begin
        m.pos_chan = 2'h1;
        m.neg_chan = 2'h0;
      end
      SEL_CH2: begin
        m.pos_chan = 2'h2;
        m.neg_chan = 2'h3;
      end
      SEL_CH3: begin
        m.pos_chan = 2'h3;
        m.neg_chan = 2'h2;
      end
      default: begin
        m.pos_chan = 2'h0;
        m.neg_chan = 2'h1;
      end
    endcase
    return m;
  endfunction

  // Two-stage synchronisers for every asynchronous input.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_meta_reg <= 5'h11;
      pin_sync_reg <= 5'h11;
      sclk_d_reg   <= 1'b0;
      cs_n_d_reg   <= 1'b1;
    end else begin
      pin_meta_reg <= {CS_N_I, SCLK_I, DIN_I, COMP_I, HW_SHUTDOWN_N_I};
      pin_sync_reg <= pin_meta_reg;
      sclk_d_reg   <= pin_sync_reg[3];
      cs_n_d_reg   <= pin_sync_reg[4];
    end
  end

  assign cs_n      = pin_sync_reg[4];
  assign sclk      = pin_sync_reg[3];
  assign din       = pin_sync_reg[2];
  assign comp      = pin_sync_reg[1];
  assign hw_shutdown_n_n    = pin_sync_reg[0];
  assign sclk_rise = sclk && !sclk_d_reg && !cs_n;
  assign sclk_fall = !sclk && sclk_d_reg && !cs_n;
  assign cs_rise   = cs_n && !cs_n_d_reg;
  assign cs_fall   = !cs_n && cs_n_d_reg;

  assign hunt_ok    = (cv_state_reg == CV_IDLE) || cs_toggled_reg
                      || ((cv_state_reg == CV_EXT) && (step_reg >= BIT3_STEP));
  assign conv_start = sclk_fall && ctrl_ready_reg;
  assign new_ext    = rx_shift_reg[CB_MODE_HI] ? rx_shift_reg[CB_MODE_LO] : clk_ext_reg;
  assign bip        = !ctrl_reg[CB_POL];

  // Control byte receiver.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_state_reg   <= RX_HUNT;
      rx_cnt_reg     <= 4'h0;
      rx_shift_reg   <= 8'h00;
      ctrl_ready_reg <= 1'b0;
    end else if (cs_n) begin
      rx_state_reg   <= RX_HUNT;
      rx_cnt_reg     <= 4'h0;
      ctrl_ready_reg <= 1'b0;
    end else if (sclk_rise) begin
      unique case (rx_state_reg)
        RX_HUNT: begin
          if (din && hunt_ok) begin
            rx_state_reg <= RX_CTRL;
            rx_shift_reg <= 8'h01;
            rx_cnt_reg   <= 4'h1;
          end
        end
        RX_CTRL: begin
          rx_shift_reg <= {rx_shift_reg[6:0], din};
          rx_cnt_reg   <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == LAST_BIT_CNT) begin
            rx_state_reg   <= RX_HUNT;
            ctrl_ready_reg <= 1'b1;
          end
        end
      endcase
    end else if (conv_start) begin
      ctrl_ready_reg <= 1'b0;
    end
  end

  // Track/hold, input multiplexer and latched configuration.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TRACK_O     <= 1'b0;
      MUX_SEL_O   <= '0;
      ctrl_reg    <= 8'h00;
      clk_ext_reg <= CLK_EXT_RST;
      pd_req_reg  <= 1'b0;
    end else if (conv_start) begin
      TRACK_O     <= 1'b0;
      ctrl_reg    <= rx_shift_reg;
      clk_ext_reg <= new_ext;
      pd_req_reg  <= !rx_shift_reg[CB_MODE_HI];
      MUX_SEL_O   <= decode_mux(rx_shift_reg[CB_SEL_HI:CB_SEL_LO], rx_shift_reg[CB_SGL]);
    end else if (sclk_fall && (rx_state_reg == RX_CTRL)) begin
      if (rx_cnt_reg == TRACK_BIT_CNT) begin
        TRACK_O <= 1'b1;
      end
      if (rx_cnt_reg == MUX_BIT_CNT) begin
        MUX_SEL_O <= decode_mux(rx_shift_reg[4:2], rx_shift_reg[0]);
      end
    end
  end

  // Successive-approximation step logic.
  assign idx       = SAR_LAST - step_reg;
  assign conv_step = ((cv_state_reg == CV_EXT) && sclk_fall)
                     || ((cv_state_reg == CV_INT) && tick
                         && ((step_reg != SAR_LAST) || fifo_in_ready));
  assign conv_last = conv_step && (step_reg == SAR_LAST);

  always_comb begin
    dec_bits      = sar_bits_reg;
    dec_bits[idx] = comp;
  end

  assign code_out            = {dec_bits[11] ^ bip, dec_bits[10:0]};
  assign push_word = '{bipolar: bip, chan_sel: ctrl_reg[CB_SEL_HI:CB_SEL_LO], code: code_out};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cv_state_reg <= CV_IDLE;
      step_reg     <= 4'h0;
      sar_bits_reg <= 12'h000;
      SAR_DAC_O    <= 12'h000;
    end else if (!hw_shutdown_n_n) begin
      cv_state_reg <= CV_IDLE;
    end else if (conv_start) begin
      cv_state_reg <= new_ext ? CV_EXT : CV_INT;
      step_reg     <= 4'h0;
      sar_bits_reg <= 12'h000;
      SAR_DAC_O    <= SAR_MSB;
    end else if (cs_rise && (cv_state_reg == CV_EXT)) begin
      cv_state_reg <= CV_IDLE;
    end else if (conv_step) begin
      sar_bits_reg <= dec_bits;
      step_reg     <= step_reg + 4'h1;
      SAR_DAC_O    <= dec_bits | (SAR_MSB >> (step_reg + 4'h1));
      if (conv_last) begin
        cv_state_reg <= CV_IDLE;
      end
    end
  end

  // Toggled chip select during a conversion reopens start detection.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cs_toggled_reg <= 1'b0;
    end else if (cs_rise && (cv_state_reg != CV_IDLE)) begin
      cs_toggled_reg <= 1'b1;
    end else if (conv_start || (cv_state_reg == CV_IDLE)) begin
      cs_toggled_reg <= 1'b0;
    end
  end

  // Conversion strobe and its drive enable.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CONV_STROBE_O    <= 1'b1;
      CONV_STROBE_OE_O <= 1'b1;
    end else begin
      CONV_STROBE_OE_O <= !(cs_n && clk_ext_reg);
      if (conv_start) begin
        CONV_STROBE_O <= new_ext;
      end else if (clk_ext_reg && (cs_n || cs_fall)) begin
        CONV_STROBE_O <= 1'b0;
      end else if (conv_step && (cv_state_reg == CV_EXT) && (step_reg == 4'h0)) begin
        CONV_STROBE_O <= 1'b0;
      end else if (conv_last && (cv_state_reg == CV_INT)) begin
        CONV_STROBE_O <= 1'b1;
      end
    end
  end

  // Serial output shifting.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      DOUT_O     <= 1'b0;
      DOUT_OE_O  <= 1'b0;
      out_sr_reg <= '0;
    end else begin
      DOUT_OE_O <= !cs_n;
      if (conv_last && (cv_state_reg == CV_INT)) begin
        out_sr_reg <= {code_out, 3'h0};
      end else if (conv_start) begin
        out_sr_reg <= '0;
        DOUT_O     <= 1'b0;
      end else if (conv_step && (cv_state_reg == CV_EXT)) begin
        DOUT_O <= (step_reg == 4'h0) ? (comp ^ bip) : comp;
      end else if (sclk_fall) begin
        DOUT_O     <= out_sr_reg[OUT_SR_W-1];
        out_sr_reg <= {out_sr_reg[OUT_SR_W-2:0], 1'b0};
      end
    end
  end

  // Power-down status and result overrun.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      POWER_DOWN_O <= 1'b0;
      OVERRUN_O    <= 1'b0;
    end else begin
      OVERRUN_O <= conv_last && !fifo_in_ready;
      if (conv_last && pd_req_reg) begin
        POWER_DOWN_O <= 1'b1;
      end else if (ctrl_ready_reg || !hw_shutdown_n_n) begin
        POWER_DOWN_O <= !hw_shutdown_n_n;
      end
    end
  end

  conv_tick_div #(
    .CYC(INT_TICK_CYC)
  ) u_tick (
    .clk_i    (CLK_I),
    .reset_n_i(RESET_N_I),
    .run_i    (cv_state_reg == CV_INT),
    .tick_o   (tick)
  );

  result_fifo #(
    .W($bits(result_s)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (CLK_I),
    .reset_n_i  (RESET_N_I),
    .in_data_i  (push_word),
    .in_valid_i (conv_last),
    .in_ready_o (fifo_in_ready),
    .out_data_o (RESULT_O),
    .out_valid_o(RESULT_VALID_O),
    .out_ready_i(RESULT_READY_I)
  );

  // Helper counting strobe-low cycles of an internal conversion.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      int_low_cnt_reg <= 9'h000;
    end else if (cv_state_reg == CV_INT) begin
      int_low_cnt_reg <= int_low_cnt_reg + 9'h001;
    end else begin
      int_low_cnt_reg <= 9'h000;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_ext_start;
    conv_start && new_ext;
  endsequence
  sequence s_first_dec;
    conv_step && (cv_state_reg == CV_EXT) && (step_reg == 4'h0);
  endsequence

  property p_din_sample;
    sclk_rise && (rx_state_reg == RX_CTRL) |=> rx_shift_reg[0] == $past(din);
  endproperty
  a_din_sample: assert property (p_din_sample) else $error("serial bit not captured");

  property p_hunt_zero;
    sclk_rise && (rx_state_reg == RX_HUNT) && !din |=> rx_state_reg == RX_HUNT;
  endproperty
  a_hunt_zero: assert property (p_hunt_zero) else $error("zero bit left hunt state");

  property p_ext_strobe;
    s_ext_start |=> CONV_STROBE_O && (cv_state_reg == CV_EXT);
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("strobe not raised");

  property p_first_dec;
    s_first_dec |=> !CONV_STROBE_O && (DOUT_O == $past(comp ^ bip));
  endproperty
  a_first_dec: assert property (p_first_dec) else $error("first decision wrong");

  property p_ext_float;
    cs_n && clk_ext_reg |=> !CONV_STROBE_OE_O && !DOUT_OE_O;
  endproperty
  a_ext_float: assert property (p_ext_float) else $error("external mode pins driven");

  property p_int_keep;
    cs_n && !clk_ext_reg |=> CONV_STROBE_OE_O && !DOUT_OE_O;
  endproperty
  a_int_keep: assert property (p_int_keep) else $error("internal mode enables wrong");

  property p_int_len;
    (int_low_cnt_reg <= 9'(STRB_LOW_MAX_CYC)) || !fifo_in_ready;
  endproperty
  a_int_len: assert property (p_int_len) else $error("internal conversion too long");

  property p_int_done;
    conv_last && (cv_state_reg == CV_INT)
      |=> CONV_STROBE_O && (out_sr_reg[14:3] == $past(code_out));
  endproperty
  a_int_done: assert property (p_int_done) else $error("internal result not held");

  property p_abort;
    cs_rise && (cv_state_reg == CV_EXT) && hw_shutdown_n_n |=> cv_state_reg == CV_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("external conversion not aborted");

  property p_cs_high;
    cs_n |=> (rx_state_reg == RX_HUNT) && !ctrl_ready_reg;
  endproperty
  a_cs_high: assert property (p_cs_high) else $error("partial byte kept");

endmodule

// *** common/adc_ctrl_pkg.sv ***
// Constants, codes and carrier types shared by the converter control block.
// Assumes a single 40 MHz system clock and an asynchronous active-low reset.
package adc_ctrl_pkg;

  // Clock and timing.
  localparam int CLK_HZ            = 40_000_000;
  localparam int CLK_PERIOD_NS     = 25;
  localparam int INT_OSC_HZ        = 1_800_000;
  localparam int INT_TICK_CYC      = CLK_HZ / INT_OSC_HZ;
  localparam int STRB_LOW_MAX_NS   = 7500;
  localparam int STRB_LOW_MAX_CYC  = STRB_LOW_MAX_NS / CLK_PERIOD_NS;

  // Control byte layout.
  localparam int CB_BITS           = 8;
  localparam int CB_SEL_HI         = 6;
  localparam int CB_SEL_LO         = 4;
  localparam int CB_POL            = 3;
  localparam int CB_SGL            = 2;
  localparam int CB_MODE_HI        = 1;
  localparam int CB_MODE_LO        = 0;
  localparam logic [3:0] TRACK_BIT_CNT = 4'h5;
  localparam logic [3:0] MUX_BIT_CNT   = 4'h6;
  localparam logic [3:0] LAST_BIT_CNT  = 4'h7;

  // Clock and power-down modes.
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT     = 2'h2;
  localparam logic [1:0] MODE_EXT     = 2'h3;
  localparam logic       CLK_EXT_RST  = 1'h0;

  // Channel select codes.
  localparam logic [2:0] SEL_CH0 = 3'h1;
  localparam logic [2:0] SEL_CH1 = 3'h5;
  localparam logic [2:0] SEL_CH2 = 3'h2;
  localparam logic [2:0] SEL_CH3 = 3'h6;

  // Conversion and readout.
  localparam int SAR_BITS           = 12;
  localparam logic [3:0] SAR_LAST   = 4'hb;
  localparam logic [3:0] BIT3_STEP  = 4'h7;
  localparam logic [11:0] SAR_MSB   = 12'h800;
  localparam int OUT_SR_W           = 15;
  localparam int FIFO_DEPTH         = 8;

  typedef struct packed {
    logic [1:0] pos_chan;
    logic [1:0] neg_chan;
    logic       neg_common;
  } mux_sel_s;

  typedef struct packed {
    logic          bipolar;
    logic [2:0]    chan_sel;
    logic [11:0]   code;
  } result_s;

endpackage

// *** hw/conv_tick_div.sv ***
// Divider giving the internal conversion clock as a one-cycle enable.
// Assumes run_i comes from logic on the same clock.
`timescale 1ns/1ps
module conv_tick_div
  import adc_ctrl_pkg::*;
#(
  parameter int CYC = INT_TICK_CYC
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Control.
  input  wire logic run_i,
  output logic      tick_o
);

  logic [7:0] cnt_reg;

  // Counts while running and pulses once per period.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b0;
    end else if (cnt_reg == 8'(CYC - 1)) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick_o  <= 1'b0;
    end
  end

endmodule

// *** hw/result_fifo.sv ***
// Shift-register FIFO holding finished conversion results.
// Assumes both sides run on the same clock; the head word sits in a flip-flop.
`timescale 1ns/1ps
module result_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // Filling side.
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Draining side.
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_reg [D];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  assign in_ready_o = (count_reg != CW'(D));
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[0];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg   <= '0;
      out_valid_o <= 1'b0;
    end else begin
      count_reg   <= count_next;
      out_valid_o <= (count_next != '0);
    end
  end

  // Each entry moves one place toward the head on a pop and takes new data at the tail.
  for (genvar i = 0; i < D; i++) begin : g_entry
    logic [W-1:0] upper;
    if (i < D - 1) begin : g_mid
      assign upper = mem_reg[i+1];
    end else begin : g_top
      assign upper = mem_reg[i];
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mem_reg[i] <= '0;
      end else if (pop) begin
        if (push && (count_reg == CW'(i + 1))) begin
          mem_reg[i] <= in_data_i;
        end else begin
          mem_reg[i] <= upper;
        end
      end else if (push && (count_reg == CW'(i))) begin
        mem_reg[i] <= in_data_i;
      end
    end
  end

endmodule

// *** testbench/spi_host_model.sv ***
// Host serial master model driving chip select, clock and data.
// Assumes the bench clock paces it; each serial clock level lasts 4 clocks.
`timescale 1ns/1ps
module spi_host_model (
  // Pacing clock.
  input  wire logic clk_i,
  // Serial link.
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic strobe_i
);
  initial begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    din_o  = 1'h0;
  end

  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  task automatic open_frame();
    @(negedge clk_i);
    cs_n_o = 1'h0;
    half();
  endtask

  // The clock rests low between frames and during internal conversions.
  task automatic fall();
    sclk_o = 1'h0;
    half();
  endtask

  task automatic close_frame();
    fall();
    cs_n_o = 1'h1;
    din_o  = ~din_o;
    half();
  endtask

  // One byte each way: data changes on the fall and is taken on the rise.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] sb);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'h0;
      din_o  = tx[i];
      half();
      sclk_o = 1'h1;
      rx[i]  = dout_i;
      sb[i]  = strobe_i;
      half();
    end
  endtask
endmodule

// *** testbench/test_adc_serial_ctrl.sv ***
// Self-checking bench for the serial converter control block.
// Assumes the host model drives the link and a bench comparator follows the DAC.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_adc_serial_ctrl
  import adc_ctrl_pkg::*;
;
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        comp = 1'h0;
  logic        rready = 1'h1;
  logic        cs_n, sclk, din, dout, dout_oe, strb, strb_oe, pd, rvalid, ovr, track;
  logic [11:0] vin = 12'h000;
  logic [11:0] sar_dac;
  mux_sel_s    mux;
  result_s     result;
  result_s     exp_q[$];
  int          err_count = 0;
  int          samples_checked = 0;
  int          ovr_cnt = 0;
  logic [2:0]  sel_codes [4] = '{SEL_CH0, SEL_CH1, SEL_CH2, SEL_CH3};
  wire         dout_pin = dout_oe ? dout : 1'bz;
  wire         strb_pin = strb_oe ? strb : 1'bz;

  spi_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
                       .dout_i(dout_pin), .strobe_i(strb_pin));
  adc_serial_ctrl DUT (
    .CLK_I(clk), .RESET_N_I(reset_n), .CS_N_I(cs_n), .SCLK_I(sclk), .DIN_I(din),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .CONV_STROBE_O(strb), .CONV_STROBE_OE_O(strb_oe),
    .COMP_I(comp), .HW_SHUTDOWN_N_I(1'h1), .SAR_DAC_O(sar_dac), .TRACK_O(track), .MUX_SEL_O(mux),
    .POWER_DOWN_O(pd), .RESULT_O(result), .RESULT_VALID_O(rvalid), .RESULT_READY_I(rready),
    .OVERRUN_O(ovr));

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) comp <= (vin >= sar_dac);
  always @(negedge clk) if (ovr === 1'h1) ovr_cnt++;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_strobe();
    int n;
    n = 0;
    while (strb_pin !== 1'h1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      err_count++;
      end_sim();
    end
    `CHK("strobe low time", 1'h1, n <= STRB_LOW_MAX_CYC)
  endtask

  task automatic ext_conv(input logic [7:0] ctrl, input logic [11:0] v);
    logic [11:0] c;
    logic [7:0]  r1, r2, s1, s2;
    c = ctrl[3] ? v : v ^ 12'h800;
    vin = v;
    host.xfer(ctrl, r1, s1);
    `CHK("track", 1'h1, track)
    if (ctrl[2]) `CHK("mux", {ctrl[5], ctrl[6], 1'h1}, {mux.pos_chan, mux.neg_common})
    else `CHK("mux", {ctrl[5], ctrl[6], ctrl[5], ~ctrl[6], 1'h0}, mux)
    host.xfer(8'h00, r1, s1);
    host.xfer(8'h00, r2, s2);
    `CHK("reply", {1'h0, c, 3'h0}, {r1, r2})
    `CHK("strobe", 16'h8000, {s1, s2})
    `CHK("hold", 1'h0, track)
    exp_q.push_back({~ctrl[3], ctrl[6:4], c});
  endtask

  task automatic t_reset();
    logic [7:0] r1, r2, s;
    repeat (6) @(negedge clk);
    `CHK("reset strobe", 3'h6, {strb, strb_oe, dout_oe})
    reset_n = 1'h1;
    host.open_frame();
    host.xfer(8'h00, r1, s);
    host.xfer(8'h00, r2, s);
    `CHK("idle reply", 16'h0000, {r1, r2})
    `CHK("idle power", 1'h0, pd)
    ext_conv({1'h1, SEL_CH2, 1'h1, 1'h1, MODE_EXT}, 12'h9e3);
    host.close_frame();
    $display("test reset done");
  endtask

  task automatic t_fifo();
    rready = 1'h0;
    exp_q.delete();
    for (int i = 0; i < 9; i++) begin
      if (i == 8) `CHK("early overrun", 0, ovr_cnt)
      host.open_frame();
      ext_conv({1'h1, sel_codes[i % 4], i[0], ~i[2], MODE_EXT}, 12'h0b7 + 12'(i) * 12'h1e5);
      host.close_frame();
    end
    `CHK("overrun", 1, ovr_cnt)
    void'(exp_q.pop_back());
    foreach (exp_q[k]) begin
      `CHK("result valid", 1'h1, rvalid)
      `CHK("result", exp_q[k], result)
      rready = 1'h1;
      @(negedge clk);
      rready = 1'h0;
      repeat (2) @(negedge clk);
    end
    `CHK("drained", 1'h0, rvalid)
    rready = 1'h1;
    $display("test fifo done");
  endtask

  task automatic t_abort();
    logic [7:0] r, s;
    host.open_frame();
    host.xfer({1'h1, SEL_CH1, 1'h1, 1'h0, MODE_EXT}, r, s);
    host.close_frame();
    `CHK("released", 2'h0, {strb_oe, dout_oe})
    host.open_frame();
    host.xfer(8'h0f, r, s);
    host.close_frame();
    host.open_frame();
    `CHK("strobe low", 2'h1, {strb, strb_oe})
    ext_conv({1'h1, SEL_CH3, 1'h0, 1'h1, MODE_EXT}, 12'h3c4);
    host.close_frame();
    $display("test abort done");
  endtask

  // Sixteen clocks per conversion: the next control byte rides on the second reply byte.
  task automatic t_overlap();
    logic [7:0] r1, r2, s;
    vin = 12'h5a6;
    host.open_frame();
    host.xfer({1'h1, SEL_CH1, 1'h1, 1'h1, MODE_EXT}, r1, s);
    host.xfer(8'h00, r1, s);
    host.xfer({1'h1, SEL_CH1, 1'h0, 1'h1, MODE_EXT}, r2, s);
    `CHK("overlap first", {1'h0, vin, 3'h0}, {r1, r2})
    host.xfer(8'h00, r1, s);
    host.xfer(8'h00, r2, s);
    `CHK("overlap second", {1'h0, vin ^ 12'h800, 3'h0}, {r1, r2})
    host.close_frame();
    $display("test overlap done");
  endtask

  task automatic t_internal();
    logic [7:0] r1, r2, s;
    vin = 12'h6c9;
    host.open_frame();
    host.xfer({1'h1, SEL_CH0, 1'h1, 1'h1, MODE_INT}, r1, s);
    host.close_frame();
    `CHK("int strobe", 2'h1, {strb, strb_oe})
    `CHK("int dout oe", 1'h0, dout_oe)
    wait_strobe();
    host.open_frame();
    host.xfer(8'h00, r1, s);
    host.xfer(8'h00, r2, s);
    `CHK("int reply", {vin, 3'h0}, {r1[6:0], r2})
    host.xfer({1'h1, SEL_CH0, 1'h1, 1'h1, MODE_FULL_PD}, r1, s);
    host.fall();
    wait_strobe();
    repeat (4) @(negedge clk);
    `CHK("power down", 1'h1, pd)
    host.close_frame();
    $display("test internal done");
  endtask

  initial begin
    t_reset();
    t_fifo();
    t_abort();
    t_overlap();
    t_internal();
    end_sim();
  end
endmodule
